// *** verilog/bscce_exec.sv ***
`timescale 1ns/100ps
module bscce_exec
    import bscce_pkg::*;
(
    input  wire logic                          sys_clk_i,
    input  wire logic                          rst_n_i,
    input  wire bscce_pkg::bscce_instr_type    instr_i,
    input  wire logic [7:0]                    reg_rdata_i,
    input  wire logic [7:0]                    accumulator_i,
    input  wire logic [7:0]                    table_high_pointer_i,
    input  wire logic [bscce_pkg::PC_WIDTH-1:0] pc_i,
    input  wire logic [bscce_pkg::STK_PTR_W-1:0] sp_i,
    output logic [bscce_pkg::REG_ADDR_W-1:0]   reg_addr_o,
    output logic                               flush_next_o,
    output logic                               busy_o,
    output logic                               pc_load_o,
    output logic [bscce_pkg::PC_WIDTH-1:0]     pc_next_o,
    output bscce_pkg::bscce_push_type          push_o,
    output logic [bscce_pkg::STK_PTR_W-1:0]    sp_next_o,
    output logic                               acc_we_o,
    output logic [7:0]                         acc_wdata_o,
    output logic                               zero_flag_we_o,
    output logic                               zero_flag_o
);
    import bscce_pkg::*;

    // second-cycle state for skip and call
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_NOP  = 3'b010,
        ST_CALL = 3'b100
    } bscce_state_type;

    bscce_state_type state_reg;
    bscce_state_type state_next;

    logic                 is_tbsc;
    logic                 is_tbss;
    logic                 is_cala;
    logic                 is_clear_accumulator;
    logic                 idle;
    logic                 test_bit;
    logic                 skip_take;
    logic [PC_WIDTH-1:0]  call_target;
    logic [PC_WIDTH-1:0]  ret_addr;

    // true when an accepted instruction carries the given operation
    function automatic logic op_hit(input bscce_instr_type ins,
                                    input logic            free,
                                    input bscce_op_type    op);
        return free && ins.valid && (ins.op == op);
    endfunction : op_hit

    // decode only when no second cycle is pending
    assign idle    = (state_reg == ST_IDLE);
    assign is_tbsc = op_hit(instr_i, idle, BSCCE_OP_TBSC);
    assign is_tbss = op_hit(instr_i, idle, BSCCE_OP_TBSS);
    assign is_cala = op_hit(instr_i, idle, BSCCE_OP_CALA);
    assign is_clear_accumulator = op_hit(instr_i, idle, BSCCE_OP_CLEAR_ACCUMULATOR);

    // register file read port addressed straight from the operand
    assign reg_addr_o = instr_i.reg_addr;
    assign test_bit   = reg_rdata_i[instr_i.bit_sel];

    assign skip_take = (is_tbsc && !test_bit) || (is_tbss && test_bit);

    assign call_target = {table_high_pointer_i[1:0], accumulator_i};
    assign ret_addr    = pc_i + 10'h001;

    always_comb begin
        state_next = ST_IDLE;
        unique case (state_reg)
            ST_IDLE: begin
                if (skip_take)
                    state_next = ST_NOP;
                else if (is_cala)
                    state_next = ST_CALL;
            end
            ST_NOP:  state_next = ST_IDLE;
            ST_CALL: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    // handshake towards fetch
    assign flush_next_o = skip_take;
    assign busy_o       = !idle;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_load_o <= 1'b0;
            pc_next_o <= PC_RESET;
        end else begin
            pc_load_o <= is_cala;
            pc_next_o <= is_cala ? call_target : pc_next_o;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            push_o    <= '0;
            sp_next_o <= SP_RESET;
        end else begin
            push_o.we   <= is_cala;
            push_o.addr <= sp_i;        // entry at the current pointer
            push_o.data <= ret_addr;    // return address
            sp_next_o   <= is_cala ? sp_i + 3'h1 : sp_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_we_o       <= 1'b0;
            acc_wdata_o    <= ACC_RESET;
            zero_flag_we_o <= 1'b0;
            zero_flag_o    <= 1'b0;
        end else begin
            acc_we_o       <= is_clear_accumulator;
            acc_wdata_o    <= ACC_CLEARED;
            zero_flag_we_o <= is_clear_accumulator;
            zero_flag_o    <= is_clear_accumulator ? 1'b1 : zero_flag_o; // holds otherwise
        end
    end

    // checks on the decoded behaviour
    // skip lasts two
    chk_skip_nop: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        skip_take |=> state_reg == ST_NOP ##1 state_reg == ST_IDLE)
        else $error("skip did not take exactly two cycles");

    chk_clear_bit: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (instr_i.valid && instr_i.op == BSCCE_OP_TBSC && !busy_o)
            |-> flush_next_o == !reg_rdata_i[instr_i.bit_sel])
        else $error("clear bit test flush wrong");

    chk_set_bit: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (instr_i.valid && instr_i.op == BSCCE_OP_TBSS && !busy_o)
            |-> flush_next_o == reg_rdata_i[instr_i.bit_sel])
        else $error("set bit test flush wrong");

    chk_flush_source: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        flush_next_o |-> instr_i.valid && !busy_o
            && (instr_i.op == BSCCE_OP_TBSC || instr_i.op == BSCCE_OP_TBSS))
        else $error("flush without a bit test");

    chk_noskip_one: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ((is_tbsc || is_tbss) && !skip_take) |=> idle)
        else $error("bit test without skip stalled");

    chk_busy_refuse: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        busy_o |-> !flush_next_o
            ##1 !(pc_load_o || push_o.we || acc_we_o))
        else $error("instruction taken while busy");

    chk_push_addr: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        is_cala |=> push_o.we
            && push_o.data == $past(pc_i) + 10'h001)
        else $error("wrong return address pushed");

    chk_call_target: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        is_cala |=> pc_load_o && pc_next_o[7:0] == $past(accumulator_i)
            && pc_next_o[9:8] == $past(table_high_pointer_i[1:0]))
        else $error("wrong call target");

    chk_sp_advance: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        is_cala |=> push_o.addr == $past(sp_i)
            && sp_next_o == $past(sp_i) + 3'h1)
        else $error("stack pointer not advanced");

    chk_clear_acc: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        is_clear_accumulator |=> acc_we_o && acc_wdata_o == 8'h00
            && zero_flag_we_o && zero_flag_o)
        else $error("accumulator clear wrong");

    // main scenarios reached
    cov_skip_clear: cover property (@(posedge sys_clk_i) is_tbsc && !test_bit);
    cov_skip_set:   cover property (@(posedge sys_clk_i) is_tbss && test_bit);
    cov_call:       cover property (@(posedge sys_clk_i) is_cala);
    cov_clear:      cover property (@(posedge sys_clk_i) is_clear_accumulator);
    cov_no_skip:    cover property (@(posedge sys_clk_i)
        (is_tbsc || is_tbss) && !skip_take);

endmodule : bscce_exec

// *** verilog/bscce_pkg.sv ***
package bscce_pkg;

    // field widths of the core datapath
    localparam int PC_WIDTH   = 10;
    localparam int REG_ADDR_W = 6;
    localparam int STK_PTR_W  = 3;

    // values after reset
    localparam logic [7:0]  ACC_RESET = 8'h00;
    localparam logic [9:0]  PC_RESET  = 10'h000;
    localparam logic [2:0]  SP_RESET  = 3'h0;

    // value forced into the accumulator by the clear
    localparam logic [7:0]  ACC_CLEARED = 8'h00;

    // cycle counts of the instructions handled here
    localparam int CYC_NO_SKIP = 1;
    localparam int CYC_SKIP    = 2;
    localparam int CYC_CALL    = 2;

    // operation selected by the instruction decoder
    typedef enum logic [2:0] {
        BSCCE_OP_NONE = 3'h0,
        BSCCE_OP_TBSC = 3'h1,
        BSCCE_OP_TBSS = 3'h2,
        BSCCE_OP_CALA = 3'h3,
        BSCCE_OP_CLEAR_ACCUMULATOR = 3'h4
    } bscce_op_type;

    // one decoded instruction handed over by fetch
    typedef struct packed {
        logic                  valid;
        bscce_op_type          op;
        logic [REG_ADDR_W-1:0] reg_addr;
        logic [2:0]            bit_sel;
    } bscce_instr_type;

    // one write into the return stack
    typedef struct packed {
        logic                  we;
        logic [STK_PTR_W-1:0]  addr;
        logic [PC_WIDTH-1:0]   data;
    } bscce_push_type;

endpackage : bscce_pkg

// *** test/test_bit_skip_call_clear_exec.sv ***
`timescale 1ns/100ps
module test_bit_skip_call_clear_exec;
    import bscce_pkg::*;
    logic                  sys_clk_i;
    logic                  rst_n_i;
    bscce_instr_type       instr_i;
    logic [7:0]            reg_rdata_i;
    logic [7:0]            accumulator_i;
    logic [7:0]            table_high_pointer_i;
    logic [PC_WIDTH-1:0]   pc_i;
    logic [STK_PTR_W-1:0]  sp_i;
    logic [REG_ADDR_W-1:0] reg_addr_o;
    logic                  flush_next_o;
    logic                  busy_o;
    logic                  pc_load_o;
    logic [PC_WIDTH-1:0]   pc_next_o;
    bscce_push_type        push_o;
    logic [STK_PTR_W-1:0]  sp_next_o;
    logic                  acc_we_o;
    logic [7:0]            acc_wdata_o;
    logic                  zero_flag_we_o;
    logic                  zero_flag_o;
    int                    fails;
    int                    checks_done;
    logic [31:0]           seed = 32'h0000_0060;
    logic [31:0]           r;
    logic [31:0]           q;

    bscce_exec u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .instr_i(instr_i), .reg_rdata_i(reg_rdata_i),
        .accumulator_i(accumulator_i),
        .table_high_pointer_i(table_high_pointer_i), .pc_i(pc_i),
        .sp_i(sp_i), .reg_addr_o(reg_addr_o), .flush_next_o(flush_next_o),
        .busy_o(busy_o), .pc_load_o(pc_load_o), .pc_next_o(pc_next_o),
        .push_o(push_o), .sp_next_o(sp_next_o), .acc_we_o(acc_we_o),
        .acc_wdata_o(acc_wdata_o), .zero_flag_we_o(zero_flag_we_o),
        .zero_flag_o(zero_flag_o));

    // free running bench clock
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic exp_skip(bscce_op_type op, logic [7:0] rd,
                                      logic [2:0] bs);
        return (op == BSCCE_OP_TBSC && !rd[bs]) ||
               (op == BSCCE_OP_TBSS && rd[bs]);
    endfunction : exp_skip

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task automatic go(bscce_op_type op, logic [5:0] ra, logic [2:0] bs,
                      logic [7:0] rd, logic [7:0] ac, logic [7:0] tb,
                      logic [9:0] pc, logic [2:0] sp);
        logic sk;
        logic cl;
        logic cz;
        logic [9:0] ret;
        logic [9:0] tgt;
        logic [2:0] spn;
        sk = exp_skip(op, rd, bs);
        cl = (op == BSCCE_OP_CALA);
        cz = (op == BSCCE_OP_CLEAR_ACCUMULATOR);
        ret = pc + 10'h001;
        tgt = {tb[1:0], ac};
        spn = cl ? sp + 3'h1 : sp;
        @(negedge sys_clk_i);
        instr_i = '{1'b1, op, ra, bs};
        reg_rdata_i = rd;
        accumulator_i = ac;
        table_high_pointer_i = tb;
        pc_i = pc;
        sp_i = sp;
        #2;
        check("reg_addr", 16'(reg_addr_o), 16'(ra));
        check("flush", 16'(flush_next_o), 16'(sk));
        @(posedge sys_clk_i);
        #1;
        check("busy", 16'(busy_o), 16'(sk | cl));
        check("pc_load", 16'(pc_load_o), 16'(cl));
        if (cl) check("pc_next", 16'(pc_next_o), 16'(tgt));
        check("push_we", 16'(push_o.we), 16'(cl));
        if (cl) check("push_addr", 16'(push_o.addr), 16'(sp));
        if (cl) check("push_data", 16'(push_o.data), 16'(ret));
        check("sp_next", 16'(sp_next_o), 16'(spn));
        check("acc_we", 16'(acc_we_o), 16'(cz));
        check("zero_we", 16'(zero_flag_we_o), 16'(cz));
        if (cz) check("acc_data", 16'(acc_wdata_o), 16'h0000);
        if (cz) check("zero_flag", 16'(zero_flag_o), 16'h0001);
        @(negedge sys_clk_i);
        instr_i = '{1'b1, BSCCE_OP_CLEAR_ACCUMULATOR, ra, bs};
        @(posedge sys_clk_i);
        #1;
        check("next_clear", 16'(acc_we_o), 16'(!(sk | cl)));
        check("pulse_gone", 16'({pc_load_o, push_o.we}), 16'h0000);
        check("busy_end", 16'(busy_o), 16'h0000);
    endtask : go

    initial begin
        #200000;
        fails++;
        wrap_up();
    end

    initial begin
        fails = 0;
        checks_done = 0;
        rst_n_i = 1'b0;
        instr_i = '0;
        reg_rdata_i = 8'h00;
        accumulator_i = 8'h00;
        table_high_pointer_i = 8'h00;
        pc_i = 10'h000;
        sp_i = 3'h0;
        repeat (4) @(negedge sys_clk_i);
        check("reset", 16'({pc_load_o, push_o.we}), 16'h0000);
        check("reset_acc", 16'(acc_we_o), 16'h0000);
        rst_n_i = 1'b1;
        go(BSCCE_OP_CALA, 6'h00, 3'h0, 8'h00, 8'h34, 8'h02, 10'h0A0, 3'h1);
        go(BSCCE_OP_CALA, 6'h3F, 3'h7, 8'hFF, 8'hFF, 8'hFF, 10'h3FF, 3'h7);
        go(BSCCE_OP_TBSC, 6'h3F, 3'h2, 8'h5A, 8'h11, 8'h00, 10'h010, 3'h0);
        go(BSCCE_OP_TBSC, 6'h01, 3'h7, 8'h80, 8'h22, 8'h00, 10'h011, 3'h2);
        go(BSCCE_OP_TBSS, 6'h00, 3'h3, 8'h5A, 8'h33, 8'h00, 10'h012, 3'h3);
        go(BSCCE_OP_TBSS, 6'h20, 3'h0, 8'hFE, 8'h44, 8'h00, 10'h013, 3'h4);
        go(BSCCE_OP_CLEAR_ACCUMULATOR, 6'h15, 3'h5, 8'h55, 8'h55, 8'h00, 10'h014, 3'h5);
        @(negedge sys_clk_i);
        instr_i = '{1'b0, BSCCE_OP_TBSC, 6'h00, 3'h0};
        reg_rdata_i = 8'h00;
        #2;
        check("idle_flush", 16'(flush_next_o), 16'h0000);
        @(negedge sys_clk_i);
        instr_i = '{1'b1, BSCCE_OP_NONE, 6'h00, 3'h0};
        #2;
        check("idle_busy", 16'({busy_o, acc_we_o}), 16'h0000);
        check("none_flush", 16'(flush_next_o), 16'h0000);
        @(posedge sys_clk_i);
        #1;
        check("none_busy", 16'({busy_o, pc_load_o}), 16'h0000);
        $display("test corner done");
        repeat (300) begin
            r = rnd();
            q = rnd();
            go(bscce_op_type'(3'(r[1:0]) + 3'h1), r[7:2], r[10:8], r[18:11],
               r[26:19], q[20:13], q[9:0], q[12:10]);
        end
        $display("test random done");
        wrap_up();
    end
endmodule : test_bit_skip_call_clear_exec
